/* File: logic/dti_io.sv */
// Debounced inputs, delayed hardware trigger and two mode-driven outputs
`timescale 1ns/100ps
`default_nettype none
module dti_io #(
    parameter int unsigned MS_CYCLES = dti_pkg::CYC_PER_MS
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic [1:0]            in_pin,
    input  wire logic [1:0][15:0]      deb_width_us,
    input  wire logic [1:0]            deb_write,
    output logic      [1:0]            filtered_input_line,
    output logic      [1:0]            in_event,
    output logic      [1:0]            event_flag,
    input  wire logic [1:0]            event_clear,
    input  wire logic                  hw_trig_enable,
    input  wire logic                  trig_src,
    input  wire logic [15:0]           trig_delay_us,
    input  wire logic                  frame_done,
    output logic                       acq_trigger,
    output logic                       trig_busy,
    input  wire dti_pkg::dti_mode_e    out_mode [2],
    input  wire logic [1:0]            out_invert,
    input  wire logic [1:0][15:0]      out_delay_ms,
    input  wire logic [1:0][15:0]      out_pulse_ms,
    input  wire logic [1:0]            out_fire,
    input  wire logic [1:0]            bypass_src,
    output logic      [1:0]            out_pending,
    output logic      [1:0]            out_line
);
    import dti_pkg::*;

    function automatic logic [DEB_CNT_W-1:0] deb_cycles(input logic [15:0] us);
        deb_cycles = DEB_CNT_W'(us) * DEB_CNT_W'(CYC_PER_US);
    endfunction

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Time base: one-cycle enables per microsecond and per millisecond
    logic [US_DIV_W-1:0] us_div_reg;
    logic [MS_DIV_W-1:0] ms_div_reg;
    logic                us_tick;
    logic                ms_tick;
    assign us_tick = (us_div_reg == US_DIV_LAST);
    assign ms_tick = (ms_div_reg == MS_DIV_W'(MS_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            us_div_reg <= '0;
        end else if (us_tick) begin
            us_div_reg <= '0;
        end else begin
            us_div_reg <= us_div_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ms_div_reg <= '0;
        end else if (ms_tick) begin
            ms_div_reg <= '0;
        end else begin
            ms_div_reg <= ms_div_reg + 1'b1;
        end
    end

    // Input filters
    logic [1:0]       sync1_reg;
    logic [1:0]       sync2_reg;
    logic [1:0]       filt_reg;
    logic [1:0]       event_reg;
    logic [1:0]       flag_reg;
    logic [1:0][15:0] deb_reg;
    logic [1:0][19:0] deb_cnt_reg;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_in
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    deb_reg[i] <= DEB_DEFAULT_US;
                end else if (deb_write[i]) begin
                    deb_reg[i] <= deb_width_us[i];
                end
            end

            // Second stage alone reads the first
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                end else begin
                    sync1_reg[i] <= in_pin[i];
                    sync2_reg[i] <= sync1_reg[i];
                end
            end

            // Any glitch back to the filtered level restarts the count
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    filt_reg[i]    <= 1'b0;
                    deb_cnt_reg[i] <= DEB_CNT_ZERO;
                    event_reg[i]   <= 1'b0;
                end else begin
                    event_reg[i] <= 1'b0;
                    if (sync2_reg[i] == filt_reg[i]) begin
                        deb_cnt_reg[i] <= DEB_CNT_ZERO;
                    end else if (deb_cnt_reg[i] >= deb_cycles(deb_reg[i])) begin
                        filt_reg[i]    <= sync2_reg[i];
                        deb_cnt_reg[i] <= DEB_CNT_ZERO;
                        event_reg[i]   <= sync2_reg[i];
                    end else begin
                        deb_cnt_reg[i] <= deb_cnt_reg[i] + 1'b1;
                    end
                end
            end

            // Set wins over a clear in the same cycle
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    flag_reg[i] <= 1'b0;
                end else if (event_reg[i]) begin
                    flag_reg[i] <= 1'b1;
                end else if (event_clear[i]) begin
                    flag_reg[i] <= 1'b0;
                end
            end

            deb_accept_a: assert property ($changed(filt_reg[i]) |->
                $past(deb_cnt_reg[i]) >= deb_cycles($past(deb_reg[i])))
                else $error("filtered level changed before debounce width");
            deb_sync_a: assert property ($changed(filt_reg[i]) |->
                filt_reg[i] == $past(sync2_reg[i]) && $past(sync2_reg[i], 2) != filt_reg[i] ||
                filt_reg[i] == $past(sync2_reg[i]))
                else $error("filtered level does not match synchronised input");
            event_rise_a: assert property (event_reg[i] |->
                filt_reg[i] && !$past(filt_reg[i]))
                else $error("input event without rising debounced edge");
            flag_set_a: assert property (event_reg[i] |=> flag_reg[i] [*1])
                else $error("sticky flag not set after event");
            flag_hold_a: assert property (flag_reg[i] && !event_clear[i] |=>
                flag_reg[i])
                else $error("sticky flag dropped without clear");
            flag_clear_a: assert property (event_clear[i] && !event_reg[i] |=>
                !flag_reg[i])
                else $error("sticky flag not cleared by write");
            sync_chain_a: assert property (sync2_reg[i] == $past(sync1_reg[i]) &&
                sync1_reg[i] == $past(in_pin[i]))
                else $error("input synchroniser stage skipped");
            deb_default_a: assert property ($past(!reset_n) |->
                deb_reg[i] == DEB_DEFAULT_US)
                else $error("debounce width not at default after reset");
            short_reject_c: cover property (sync2_reg[i] != filt_reg[i] ##1
                sync2_reg[i] == filt_reg[i] && deb_cnt_reg[i] != DEB_CNT_ZERO);
            in_event_c: cover property (event_reg[i]);
            flag_race_c: cover property (event_reg[i] && event_clear[i]);
        end
    endgenerate

    assign filtered_input_line = filt_reg;
    assign in_event            = event_reg;
    assign event_flag          = flag_reg;

    // Hardware trigger: delay, one frame, back to standby
    // Trigger pulses shorter than the minimum hold may be filtered out
    dti_trg_e    trg_state_reg;
    logic [15:0] trg_cnt_reg;
    logic        acq_reg;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            trg_state_reg <= DTI_TRG_IDLE;
            trg_cnt_reg   <= CNT16_ZERO;
            acq_reg       <= 1'b0;
        end else begin
            acq_reg <= 1'b0;
            case (trg_state_reg)
                DTI_TRG_IDLE: begin
                    if (hw_trig_enable && event_reg[trig_src]) begin
                        trg_cnt_reg   <= trig_delay_us;
                        trg_state_reg <= DTI_TRG_DELAY;
                    end
                end
                DTI_TRG_DELAY: begin
                    if (!hw_trig_enable) begin
                        trg_state_reg <= DTI_TRG_IDLE;
                    end else if (trg_cnt_reg == CNT16_ZERO) begin
                        acq_reg       <= 1'b1;
                        trg_state_reg <= DTI_TRG_FRAME;
                    end else if (us_tick) begin
                        trg_cnt_reg <= trg_cnt_reg - 1'b1;
                    end
                end
                DTI_TRG_FRAME: begin
                    // Triggers arriving mid-frame are dropped
                    if (frame_done || !hw_trig_enable) begin
                        trg_state_reg <= DTI_TRG_IDLE;
                    end
                end
                default: trg_state_reg <= DTI_TRG_IDLE;
            endcase
        end
    end

    assign acq_trigger = acq_reg;
    assign trig_busy   = (trg_state_reg != DTI_TRG_IDLE);

    trig_delay_a: assert property (acq_reg |->
        $past(trg_state_reg) == DTI_TRG_DELAY && $past(trg_cnt_reg) == CNT16_ZERO)
        else $error("internal trigger without completed delay");
    trig_once_a: assert property (acq_reg |-> trg_state_reg == DTI_TRG_FRAME ##1 !acq_reg)
        else $error("more than one internal trigger per frame");
    frame_end_a: assert property (trg_state_reg == DTI_TRG_FRAME && frame_done |=>
        trg_state_reg == DTI_TRG_IDLE)
        else $error("no return to standby after frame");
    trig_abort_a: assert property (!hw_trig_enable |=> trg_state_reg == DTI_TRG_IDLE)
        else $error("trigger stays busy after mode off");
    acq_trig_c: cover property (acq_reg ##[1:1000] frame_done);

    // Outputs: mode logic, then inverter, then flip-flop
    logic [1:0]       pend_reg;
    logic [1:0]       act_reg;
    logic [1:0][15:0] out_cnt_reg;
    logic [1:0]       line_reg;

    generate
        for (i = 0; i < 2; i++) begin : g_out
            always_ff @(posedge clk) begin
                if (!reset_n || out_mode[i] != DTI_OUT_DIRECT) begin
                    pend_reg[i]    <= 1'b0;
                    act_reg[i]     <= 1'b0;
                    out_cnt_reg[i] <= CNT16_ZERO;
                end else if (pend_reg[i]) begin
                    if (out_cnt_reg[i] == CNT16_ZERO) begin
                        pend_reg[i]    <= 1'b0;
                        act_reg[i]     <= 1'b1;
                        out_cnt_reg[i] <= out_pulse_ms[i];
                    end else if (ms_tick) begin
                        out_cnt_reg[i] <= out_cnt_reg[i] - 1'b1;
                    end
                end else if (act_reg[i]) begin
                    if (out_cnt_reg[i] == CNT16_ZERO) begin
                        act_reg[i] <= 1'b0;
                    end else if (ms_tick) begin
                        out_cnt_reg[i] <= out_cnt_reg[i] - 1'b1;
                    end
                end else if (out_fire[i]) begin
                    pend_reg[i]    <= 1'b1;
                    out_cnt_reg[i] <= out_delay_ms[i];
                end
            end

            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    line_reg[i] <= 1'b0;
                end else begin
                    case (out_mode[i])
                        DTI_OUT_LOW:    line_reg[i] <= out_invert[i];
                        DTI_OUT_HIGH:   line_reg[i] <= ~out_invert[i];
                        DTI_OUT_DIRECT: line_reg[i] <= act_reg[i] ^ out_invert[i];
                        DTI_OUT_BYPASS: line_reg[i] <= filt_reg[bypass_src[i]] ^ out_invert[i];
                        default:        line_reg[i] <= out_invert[i];
                    endcase
                end
            end

            out_static_a: assert property (out_mode[i] == DTI_OUT_HIGH |=>
                line_reg[i] == ~$past(out_invert[i]))
                else $error("static high output wrong");
            out_low_a: assert property (out_mode[i] == DTI_OUT_LOW |=>
                line_reg[i] == $past(out_invert[i]))
                else $error("static low output wrong");
            out_bypass_a: assert property (out_mode[i] == DTI_OUT_BYPASS |=>
                line_reg[i] == ($past(filt_reg[bypass_src[i]]) ^ $past(out_invert[i])))
                else $error("bypass output does not follow input");
            out_direct_a: assert property ($rose(act_reg[i]) |->
                $past(pend_reg[i]) && $past(out_cnt_reg[i]) == CNT16_ZERO)
                else $error("direct output active before delay elapsed");
            out_invert_a: assert property (out_mode[i] == DTI_OUT_DIRECT |=>
                line_reg[i] == ($past(act_reg[i]) ^ $past(out_invert[i])))
                else $error("direct output polarity wrong");
            out_fire_c: cover property ($rose(act_reg[i]));
        end
    endgenerate

    assign out_pending = pend_reg;
    assign out_line    = line_reg;
endmodule
`default_nettype wire

/* File: logic/dti_pkg.sv */
// Constants and types for the debounced trigger I/O block
package dti_pkg;
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned CYC_PER_US       = CLK_HZ / 1_000_000;
    localparam int unsigned CYC_PER_MS       = CLK_HZ / 1_000;
    // Trigger input debounce after reset, in microseconds (50)
    localparam logic [15:0] DEB_DEFAULT_US   = 16'h0032;
    // Shortest trigger pulse the source must hold, in milliseconds
    localparam int unsigned TRIG_MIN_HOLD_MS = 16;
    localparam int unsigned DEB_CNT_W        = 20;
    localparam int unsigned US_DIV_W         = 4;
    localparam int unsigned MS_DIV_W         = 16;
    localparam logic [3:0]  US_DIV_LAST      = 4'(CYC_PER_US - 1);
    localparam logic [15:0] CNT16_ZERO       = 16'h0000;
    localparam logic [19:0] DEB_CNT_ZERO     = 20'h00000;

    typedef enum logic [1:0] {
        DTI_OUT_LOW    = 2'b00,
        DTI_OUT_HIGH   = 2'b01,
        DTI_OUT_DIRECT = 2'b10,
        DTI_OUT_BYPASS = 2'b11
    } dti_mode_e;

    typedef enum logic [1:0] {
        DTI_TRG_IDLE  = 2'b00,
        DTI_TRG_DELAY = 2'b01,
        DTI_TRG_FRAME = 2'b10
    } dti_trg_e;

    localparam dti_mode_e OUT_MODE_RST = DTI_OUT_LOW;
endpackage

/* File: sim/dti_field_model.sv */
// Behavioural sensors, trigger source and acquisition side of the I/O block
`timescale 1ns/100ps
`default_nettype none
module dti_field_model #(
    parameter int unsigned MS_CYCLES = dti_pkg::CYC_PER_MS
) (
    input  wire logic       clk,
    input  wire logic       acq_trigger,
    output logic      [1:0] in_pin,
    output logic            frame_done
);
    // Long enough that a second trigger lands inside a frame
    int frame_len = 800;
    initial begin
        in_pin = 2'b00;
        frame_done = 1'b0;
    end
    // Source holds the level for the given number of cycles, then releases it
    task automatic pulse(input int idx, input int cycles);
        @(posedge clk) #1;
        in_pin[idx] = 1'b1;
        repeat (cycles) @(posedge clk);
        #1;
        in_pin[idx] = 1'b0;
    endtask
    // Trigger source keeps the shortest legal hold, in scaled milliseconds
    task automatic trig_pulse(input int idx);
        pulse(idx, int'(dti_pkg::TRIG_MIN_HOLD_MS * MS_CYCLES));
    endtask
    // Slow acquisition side: one frame per internal trigger
    always @(posedge clk) begin
        if (acq_trigger === 1'b1) begin
            repeat (frame_len) @(posedge clk);
            #1 frame_done = 1'b1;
            @(posedge clk) #1 frame_done = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the debounced trigger I/O block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import dti_pkg::*;
    logic             clk, reset_n, hw_trig_enable, trig_src, frame_done, acq_trigger, trig_busy;
    logic [1:0]       in_pin, deb_write, filtered_input_line, in_event, event_flag, event_clear;
    logic [1:0]       out_invert, out_fire, bypass_src, out_pending, out_line;
    logic [1:0][15:0] deb_width_us, out_delay_ms, out_pulse_ms;
    logic [15:0]      trig_delay_us;
    dti_mode_e        out_mode [2];
    int               err_count = 0, n_tests = 0, cycles = 0, acq_cnt = 0, n;

    dti_io #(.MS_CYCLES(20)) dti_io_i (.clk(clk), .reset_n(reset_n), .in_pin(in_pin),
        .deb_width_us(deb_width_us), .deb_write(deb_write), .in_event(in_event),
        .filtered_input_line(filtered_input_line), .event_flag(event_flag),
        .event_clear(event_clear), .hw_trig_enable(hw_trig_enable), .trig_src(trig_src),
        .trig_delay_us(trig_delay_us), .frame_done(frame_done), .acq_trigger(acq_trigger),
        .trig_busy(trig_busy), .out_mode(out_mode), .out_invert(out_invert),
        .out_delay_ms(out_delay_ms), .out_pulse_ms(out_pulse_ms), .out_fire(out_fire),
        .bypass_src(bypass_src), .out_pending(out_pending), .out_line(out_line));
    dti_field_model #(.MS_CYCLES(20)) dti_field_model_i (.clk(clk), .acq_trigger(acq_trigger),
        .in_pin(in_pin), .frame_done(frame_done));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard; the full run needs about 3000 cycles
    always @(posedge clk) begin
        cycles++;
        if (acq_trigger === 1'b1) acq_cnt++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    // Input 1 narrowed to 2 us; the exact acceptance cycle is pinned down
    task automatic t_filter;
        deb_width_us[1] = 16'h0002;
        deb_write = 2'b10;
        step();
        deb_write = 2'b00;
        dti_field_model_i.pulse(1, 19);
        step(30);
        check(event_flag[1], 1'b0);
        fork
            dti_field_model_i.pulse(1, 30);
            begin
                step();
                n = 0;
                while (filtered_input_line[1] !== 1'b1 && n < 100) begin
                    step();
                    n++;
                end
                check(n, 23);
                check(in_event, 2'b10);
                step();
                check(in_event, 2'b00);
                check(event_flag, 2'b10);
            end
        join
        step(30);
        check(event_flag, 2'b10);
        event_clear = 2'b10;
        step();
        event_clear = 2'b00;
        check(event_flag, 2'b00);
    endtask
    // Input 0 keeps its own reset width while input 1 was changed
    task automatic t_default_width;
        dti_field_model_i.pulse(0, 480);
        step(40);
        check(event_flag[0], 1'b0);
        dti_field_model_i.pulse(0, 520);
        step(10);
        check(event_flag[0], 1'b1);
    endtask
    task automatic t_trigger;
        hw_trig_enable = 1'b1;
        trig_src = 1'b1;
        trig_delay_us = 16'h0003;
        fork
            dti_field_model_i.trig_pulse(1);
            begin
                n = 0;
                while (in_event[1] !== 1'b1 && n < 100) begin
                    step();
                    n++;
                end
                n = 0;
                while (acq_trigger !== 1'b1 && n < 100) begin
                    step();
                    n++;
                end
                check(n >= 23 && n <= 32, 1'b1);
                check(trig_busy, 1'b1);
            end
        join
        step(30);
        dti_field_model_i.trig_pulse(1);
        step(30);
        check(acq_cnt, 1);
        n = 0;
        while (trig_busy !== 1'b0 && n < 400) begin
            step();
            n++;
        end
        check(trig_busy, 1'b0);
        dti_field_model_i.trig_pulse(1);
        step(60);
        check(acq_cnt, 2);
        hw_trig_enable = 1'b0;
    endtask
    task automatic t_static;
        for (int k = 0; k < 4; k++) begin
            out_mode[0] = k[0] ? DTI_OUT_HIGH : DTI_OUT_LOW;
            out_mode[1] = out_mode[0];
            out_invert = {k[1], ~k[1]};
            step(2);
            check(out_line, {k[0] ^ k[1], k[0] ^ ~k[1]});
        end
    endtask
    // Second fire lands while active and must not stretch the pulse
    task automatic t_direct;
        out_invert = 2'b00;
        out_mode[1] = DTI_OUT_DIRECT;
        out_delay_ms[1] = 16'h0002;
        out_pulse_ms[1] = 16'h0003;
        step(2);
        out_fire = 2'b10;
        step();
        out_fire = 2'b00;
        check(out_pending[1], 1'b1);
        n = 1;
        while (out_line[1] !== 1'b1 && n < 200) begin
            step();
            n++;
        end
        check(n >= 21 && n <= 45, 1'b1);
        out_fire = 2'b10;
        step();
        out_fire = 2'b00;
        n = 1;
        while (out_line[1] === 1'b1 && n < 200) begin
            step();
            n++;
        end
        check(n >= 40 && n <= 62, 1'b1);
        step(80);
        check({out_pending[1], out_line[1]}, 2'b00);
    endtask
    task automatic t_bypass;
        out_mode[0] = DTI_OUT_BYPASS;
        bypass_src[0] = 1'b1;
        out_invert = 2'b01;
        step(2);
        check(out_line[0], 1'b1);
        dti_field_model_i.pulse(1, 30);
        step(2);
        check(out_line[0], 1'b0);
    endtask
    initial begin
        reset_n = 1'b0;
        {hw_trig_enable, trig_src, trig_delay_us} = '0;
        {deb_width_us, deb_write, event_clear} = '0;
        {out_invert, out_fire, bypass_src, out_delay_ms, out_pulse_ms} = '0;
        out_mode[0] = DTI_OUT_LOW;
        out_mode[1] = DTI_OUT_LOW;
        step(2);
        reset_n = 1'b1;
        step(2);
        check(out_line, 2'b00);
        t_filter();
        t_default_width();
        t_trigger();
        t_static();
        t_direct();
        t_bypass();
        end_of_test();
    end
endmodule
`default_nettype wire
